/* File: core/dcr_pkg.sv */
// Package with the register map and field layout of the down-converter configuration bank
// Notes on behaviour
// - Filters 0,2: code 00 connects, 01 disconnects
// - Filters 1,3: code 00 disconnects, 01 connects
// - Rising strobe bits 7..4 load oscillators 3..0
// - Negative image applies only in complex mode
// - Mode bit: continuous or infinite phase coherent
// - Low-latency bit bypasses all digital processing
// - Disable bit stops pin-switch automatic frequency loads
// - Select bit: pins or selection register source
// - Rising common bit loads all four oscillators
// - Per-filter field picks active frequency, register mode
// - Per-filter decimation nibbles apply in unequal mode
// - Code 0 bypasses, 1 by 2, 15 by 32768
// - Unequal bit picks common or per-filter factors
// - Complex enable picks real or complex decimation
package dcr_pkg;
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFS_SRC = 12'h163;
    localparam logic [ADDR_W-1:0] OFS_OSC = 12'h164;
    localparam logic [ADDR_W-1:0] OFS_FEAT = 12'h165;
    localparam logic [ADDR_W-1:0] OFS_FSEL = 12'h166;
    localparam logic [ADDR_W-1:0] OFS_DEC_A = 12'h167;
    localparam logic [ADDR_W-1:0] OFS_DEC_B = 12'h168;
    localparam logic [7:0] RST_SRC = 8'h00;
    localparam logic [7:0] RST_OSC = 8'h00;
    localparam logic [7:0] RST_FEAT = 8'h00;
    localparam logic [7:0] RST_FSEL = 8'h00;
    localparam logic [7:0] RST_DEC = 8'h00;
    localparam int OSC_LOAD_LSB = 4;
    localparam int OSC_NEG_IMAGE = 3;
    localparam int OSC_PHASE_MODE = 0;
    localparam int FEAT_LOW_LAT = 4;
    localparam int FEAT_AUTO_DIS = 2;
    localparam int FEAT_REG_SEL = 1;
    localparam int FEAT_COMMON_LOAD = 0;
    localparam logic [1:0] SRC_EVEN_ON = 2'h0;
    localparam logic [1:0] SRC_ODD_ON = 2'h1;
    localparam logic [3:0] DEC_BYPASS = 4'h0;
endpackage : dcr_pkg

/* File: core/dcr_decim_dec.sv */
// Decimation code selection and decode for one filter
`timescale 1ns/10ps
`default_nettype none
module dcr_decim_dec
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // Codes and modes
    input wire logic [3:0] i_code,
    input wire logic [3:0] i_common_code,
    input wire logic i_unequal,
    input wire logic i_low_latency,
    // Decoded result
    output logic o_bypass,
    output logic [3:0] o_log2,
    output logic [15:0] o_factor
);
    import dcr_pkg::*;

    logic [3:0] code_nxt;

    assign code_nxt = i_unequal ? i_code : i_common_code;

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_bypass <= 1'b1;
            o_log2 <= 4'h0;
            o_factor <= 16'h0001;
        end
        else
        begin
            // Bypass reports factor one so downstream never sees a zero ratio
            o_bypass <= i_low_latency || (code_nxt == DEC_BYPASS);
            o_log2 <= i_low_latency ? 4'h0 : code_nxt;
            o_factor <= i_low_latency ? 16'h0001 : (16'h0001 << code_nxt);
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);

    decim_pick_a: assert property (i_unequal && !i_low_latency |=> o_log2 == $past(i_code))
        else $error("per-filter code not taken in unequal mode");
    decim_common_a: assert property (!i_unequal && !i_low_latency |=> o_log2 == $past(i_common_code))
        else $error("common code not taken");
    decim_factor_a: assert property (o_factor == (16'h0001 << o_log2))
        else $error("factor not two to the code");
    decim_bypass_a: assert property (o_bypass == (o_log2 == DEC_BYPASS))
        else $error("bypass flag disagrees with code");
endmodule : dcr_decim_dec
`default_nettype wire

/* File: core/dcr_regs.sv */
// Down-converter and oscillator configuration register bank
`timescale 1ns/10ps
`default_nettype none
module dcr_regs
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // Register port from the serial control decoder
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [dcr_pkg::ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    output logic o_rd_valid,
    // Fields held in neighbouring registers
    input wire logic i_complex_decim_enable,
    input wire logic i_unequal_decim,
    input wire logic [3:0] i_common_decim_code,
    // Frequency selection pins, two per filter
    input wire logic [7:0] i_pin_freq_select,
    // Controls to the processing path
    output logic [3:0] o_filter_connected,
    output logic [3:0] o_osc_load,
    output logic o_negative_image,
    output logic o_phase_coherent,
    output logic o_complex_mode,
    output logic o_low_latency,
    output logic [7:0] o_freq_select,
    output logic [3:0] o_decim_bypass,
    output logic [15:0] o_decim_log2,
    output logic [63:0] o_decim_factor
);
    import dcr_pkg::*;

    logic [7:0] src_r;
    logic [7:0] osc_r;
    logic [7:0] feat_r;
    logic [7:0] fsel_r;
    logic [7:0] dec_a_r;
    logic [7:0] dec_b_r;
    logic [7:0] pin_prev_r;
    logic [7:0] rdata_nxt;
    logic [3:0] load_nxt;
    logic [3:0] osc_rise;
    logic [3:0] pin_change;
    logic common_rise;
    logic [15:0] dec_codes;

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            src_r <= RST_SRC;
            osc_r <= RST_OSC;
            feat_r <= RST_FEAT;
            fsel_r <= RST_FSEL;
            dec_a_r <= RST_DEC;
            dec_b_r <= RST_DEC;
        end
        else if (i_wr_en)
        begin
            // Reserved bits are stored as written; software keeps them zero
            case (i_addr)
                OFS_SRC: src_r <= i_wdata;
                OFS_OSC: osc_r <= i_wdata;
                OFS_FEAT: feat_r <= i_wdata;
                OFS_FSEL: fsel_r <= i_wdata;
                OFS_DEC_A: dec_a_r <= i_wdata;
                OFS_DEC_B: dec_b_r <= i_wdata;
                default: ;
            endcase
        end
    end

    always_comb
    begin
        case (i_addr)
            OFS_SRC: rdata_nxt = src_r;
            OFS_OSC: rdata_nxt = osc_r;
            OFS_FEAT: rdata_nxt = feat_r;
            OFS_FSEL: rdata_nxt = fsel_r;
            OFS_DEC_A: rdata_nxt = dec_a_r;
            OFS_DEC_B: rdata_nxt = dec_b_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_rdata <= 8'h00;
            o_rd_valid <= 1'b0;
        end
        else
        begin
            o_rd_valid <= i_rd_en;
            if (i_rd_en)
            begin
                o_rdata <= rdata_nxt;
            end
        end
    end

    // Edges are taken against the stored bit, so rewriting a 1 loads nothing
    assign common_rise = i_wr_en && (i_addr == OFS_FEAT) && i_wdata[FEAT_COMMON_LOAD]
                         && !feat_r[FEAT_COMMON_LOAD];

    generate
        for (genvar g = 0; g < 4; g++)
        begin : g_osc
            assign osc_rise[g] = i_wr_en && (i_addr == OFS_OSC) && i_wdata[OSC_LOAD_LSB + g]
                                 && !osc_r[OSC_LOAD_LSB + g];
            // Pin switching reloads only while the pins are the selection source
            assign pin_change[g] = !feat_r[FEAT_REG_SEL] && !feat_r[FEAT_AUTO_DIS]
                                   && (i_pin_freq_select[2*g +: 2] != pin_prev_r[2*g +: 2]);
        end
    endgenerate

    assign load_nxt = osc_rise | {4{common_rise}} | pin_change;

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_osc_load <= 4'h0;
            pin_prev_r <= 8'h00;
        end
        else
        begin
            o_osc_load <= load_nxt;
            pin_prev_r <= i_pin_freq_select;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_filter_connected <= 4'h0;
            o_negative_image <= 1'b0;
            o_phase_coherent <= 1'b0;
            o_complex_mode <= 1'b0;
            o_low_latency <= 1'b0;
            o_freq_select <= 8'h00;
        end
        else
        begin
            // Low latency cuts every filter off its source
            o_filter_connected[0] <= !feat_r[FEAT_LOW_LAT] && (src_r[1:0] == SRC_EVEN_ON);
            o_filter_connected[1] <= !feat_r[FEAT_LOW_LAT] && (src_r[3:2] == SRC_ODD_ON);
            o_filter_connected[2] <= !feat_r[FEAT_LOW_LAT] && (src_r[5:4] == SRC_EVEN_ON);
            o_filter_connected[3] <= !feat_r[FEAT_LOW_LAT] && (src_r[7:6] == SRC_ODD_ON);
            o_negative_image <= osc_r[OSC_NEG_IMAGE] && i_complex_decim_enable;
            o_phase_coherent <= osc_r[OSC_PHASE_MODE];
            o_complex_mode <= i_complex_decim_enable;
            o_low_latency <= feat_r[FEAT_LOW_LAT];
            o_freq_select <= feat_r[FEAT_REG_SEL] ? fsel_r : i_pin_freq_select;
        end
    end

    assign dec_codes = {dec_b_r, dec_a_r};

    generate
        for (genvar f = 0; f < 4; f++)
        begin : g_dec
            dcr_decim_dec u_dec
            (
                .i_sys_clk(i_sys_clk),
                .i_arst_n(i_arst_n),
                .i_code(dec_codes[4*f +: 4]),
                .i_common_code(i_common_decim_code),
                .i_unequal(i_unequal_decim),
                .i_low_latency(feat_r[FEAT_LOW_LAT]),
                .o_bypass(o_decim_bypass[f]),
                .o_log2(o_decim_log2[4*f +: 4]),
                .o_factor(o_decim_factor[16*f +: 16])
            );
        end
    endgenerate

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);

    sequence common_wr_s;
        i_wr_en && (i_addr == OFS_FEAT) && i_wdata[FEAT_COMMON_LOAD] && !feat_r[FEAT_COMMON_LOAD];
    endsequence

    sequence all_load_s;
        // One pulse only on oscillator 0, unless a fresh write or pin change asks again
        (o_osc_load == 4'hf)
            ##1 (!o_osc_load[0] || $past(i_wr_en) || $past(pin_change[0]));
    endsequence

    src_even_map_a: assert property ((src_r[1:0] == SRC_EVEN_ON) && !feat_r[FEAT_LOW_LAT]
        |=> o_filter_connected[0])
        else $error("filter 0 not connected on code 00");
    src_odd_map_a: assert property ((src_r[3:2] != SRC_ODD_ON) |=> !o_filter_connected[1])
        else $error("filter 1 connected on wrong code");
    osc_edge_load_a: assert property (i_wr_en && (i_addr == OFS_OSC) && i_wdata[7] && !osc_r[7]
        |=> o_osc_load[3])
        else $error("oscillator 3 not loaded on rising strobe");
    neg_image_gate_a: assert property (o_negative_image |-> $past(osc_r[OSC_NEG_IMAGE])
        && $past(i_complex_decim_enable))
        else $error("negative image outside complex mode");
    phase_mode_a: assert property (1'b1 |=> o_phase_coherent == $past(osc_r[OSC_PHASE_MODE]))
        else $error("phase mode does not follow register");
    low_latency_a: assert property (feat_r[FEAT_LOW_LAT]
        |=> (o_filter_connected == 4'h0) && (o_decim_bypass == 4'hf) && o_low_latency)
        else $error("low latency does not bypass processing");
    autoload_off_a: assert property (feat_r[FEAT_AUTO_DIS] && !i_wr_en |=> o_osc_load == 4'h0)
        else $error("load while pin autoload disabled");
    sel_source_a: assert property (feat_r[FEAT_REG_SEL] |=> o_freq_select == $past(fsel_r))
        else $error("register selection not applied");
    common_load_a: assert property (common_wr_s |=> all_load_s)
        else $error("common strobe did not load all oscillators");
    no_rewrite_a: assert property (i_wr_en && (i_addr == OFS_OSC) && osc_r[4] && i_wdata[4]
        && !pin_change[0] |=> !o_osc_load[0])
        else $error("rewriting a set strobe loaded again");
endmodule : dcr_regs
`default_nettype wire

/* File: test/dcr_regs_bench.sv */
// Self-checking bench for the down-converter configuration register bank
`timescale 1ns/10ps
`default_nettype none
module dcr_regs_bench;
    import dcr_pkg::*;
    typedef struct packed {
        logic [ADDR_W-1:0] a;
        logic [7:0] d;
        logic c, u;
        logic [3:0] cc, con;
        logic neg, ph, ll;
        logic [15:0] l2;
    } dcr_row_s;
    logic clk = 1'h0, rst_n = 1'h0, wr = 1'h0, rd = 1'h0, cplx = 1'h0, uneq = 1'h0;
    logic [ADDR_W-1:0] addr = 12'h000;
    logic [7:0] wd = 8'h00, pins = 8'h00, rdata, fsel;
    logic [3:0] cc = 4'h0, conn, load, byp;
    logic rv, neg, ph, cm, ll;
    logic [15:0] l2;
    logic [63:0] fac;
    int n_mismatch = 0, compares = 0;
    dcr_row_s r;
    // Rows accumulate register state, so each row's outputs depend on the rows above it
    dcr_row_s rows [12] = '{
        '{12'h163, 8'h44, 1'h0, 1'h0, 4'h0, 4'hf, 1'h0, 1'h0, 1'h0, 16'h0000},
        '{12'h163, 8'haa, 1'h0, 1'h0, 4'h0, 4'h0, 1'h0, 1'h0, 1'h0, 16'h0000},
        '{12'h163, 8'h00, 1'h0, 1'h0, 4'h0, 4'h5, 1'h0, 1'h0, 1'h0, 16'h0000},
        '{12'h167, 8'hf1, 1'h0, 1'h1, 4'h3, 4'h5, 1'h0, 1'h0, 1'h0, 16'h00f1},
        '{12'h168, 8'h2e, 1'h0, 1'h1, 4'h3, 4'h5, 1'h0, 1'h0, 1'h0, 16'h2ef1},
        '{12'h163, 8'h44, 1'h0, 1'h0, 4'h5, 4'hf, 1'h0, 1'h0, 1'h0, 16'h5555},
        '{12'h164, 8'h08, 1'h0, 1'h0, 4'h5, 4'hf, 1'h0, 1'h0, 1'h0, 16'h5555},
        '{12'h164, 8'h08, 1'h1, 1'h0, 4'h5, 4'hf, 1'h1, 1'h0, 1'h0, 16'h5555},
        '{12'h164, 8'h09, 1'h1, 1'h0, 4'h5, 4'hf, 1'h1, 1'h1, 1'h0, 16'h5555},
        '{12'h165, 8'h10, 1'h1, 1'h0, 4'h5, 4'h0, 1'h1, 1'h1, 1'h1, 16'h0000},
        '{12'h165, 8'h00, 1'h0, 1'h1, 4'h0, 4'hf, 1'h0, 1'h1, 1'h0, 16'h2ef1},
        '{12'h163, 8'hff, 1'h0, 1'h0, 4'hf, 4'h0, 1'h0, 1'h1, 1'h0, 16'hffff}};

    dcr_regs uut (.i_sys_clk(clk), .i_arst_n(rst_n), .i_wr_en(wr), .i_rd_en(rd),
        .i_addr(addr), .i_wdata(wd), .o_rdata(rdata), .o_rd_valid(rv),
        .i_complex_decim_enable(cplx), .i_unequal_decim(uneq), .i_common_decim_code(cc),
        .i_pin_freq_select(pins), .o_filter_connected(conn), .o_osc_load(load),
        .o_negative_image(neg), .o_phase_coherent(ph), .o_complex_mode(cm),
        .o_low_latency(ll), .o_freq_select(fsel), .o_decim_bypass(byp),
        .o_decim_log2(l2), .o_decim_factor(fac));

    initial
    begin
        forever #12.5 clk = ~clk;
    end

    task automatic print_verdict;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %0h expected %0h", $time, m, got, exp);
        end
    endtask : chk

    // Every driver change lands 2 ns after an edge, never on it
    task automatic tick;
        @(posedge clk);
        #2;
    endtask : tick

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        addr = a;
        wd = d;
        wr = 1'h1;
        tick();
        wr = 1'h0;
    endtask : wr_reg

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        addr = a;
        rd = 1'h1;
        tick();
        rd = 1'h0;
        chk(rv, 1'h1, "read valid");
        chk(rdata, e, "read data");
        tick();
        chk(rv, 1'h0, "valid width");
    endtask : rd_chk

    // Window of four samples: a missing, doubled or stray load pulse all fail
    task automatic pulse_chk(input logic [3:0] e);
        int hits;
        hits = 0;
        repeat (4)
        begin
            if (load !== 4'h0)
                hits += (load === e) ? 1 : 99;
            tick();
        end
        chk(hits, (e == 4'h0) ? 0 : 1, "load pulse");
    endtask : pulse_chk

    initial
    begin
        #(25 * 3000);
        n_mismatch++;
        print_verdict();
    end

    initial
    begin
        repeat (5) @(posedge clk);
        #2;
        chk(byp, 4'hf, "reset bypass");
        chk(fac, {4{16'h0001}}, "reset factor");
        rst_n = 1'h1;
        tick();
        for (logic [ADDR_W-1:0] a = 12'h163; a <= 12'h168; a++)
            rd_chk(a, 8'h00);
        foreach (rows[i])
        begin
            r = rows[i];
            cplx = r.c;
            uneq = r.u;
            cc = r.cc;
            wr_reg(r.a, r.d);
            tick();
            tick();
            chk(conn, r.con, "source");
            chk({neg, cm}, {r.neg, r.c}, "image");
            chk(ph, r.ph, "phase mode");
            chk(ll, r.ll, "low latency");
            chk(l2, r.l2, "decim code");
            for (int f = 0; f < 4; f++)
            begin
                chk(byp[f], r.l2[4*f +: 4] == 4'h0, "bypass");
                chk(fac[16*f +: 16], 16'h0001 << r.l2[4*f +: 4], "factor");
            end
            rd_chk(r.a, r.d);
        end
        wr_reg(12'h164, 8'h00);
        pulse_chk(4'h0);
        for (int n = 0; n < 4; n++)
        begin
            wr_reg(12'h164, 8'h10 << n);
            pulse_chk(4'h1 << n);
            wr_reg(12'h164, 8'h10 << n);
            pulse_chk(4'h0);
            wr_reg(12'h164, 8'h00);
            pulse_chk(4'h0);
        end
        wr_reg(12'h165, 8'h01);
        pulse_chk(4'hf);
        wr_reg(12'h165, 8'h01);
        pulse_chk(4'h0);
        wr_reg(12'h165, 8'h00);
        tick();
        wr_reg(12'h166, 8'h1b);
        pins = 8'he4;
        pulse_chk(4'he);
        chk(fsel, 8'he4, "pin select");
        wr_reg(12'h165, 8'h02);
        pins = 8'h00;
        pulse_chk(4'h0);
        chk(fsel, 8'h1b, "reg select");
        wr_reg(12'h165, 8'h04);
        pins = 8'hff;
        pulse_chk(4'h0);
        chk(fsel, 8'hff, "pin select");
        wr_reg(12'h165, 8'h00);
        pins = 8'h0f;
        pulse_chk(4'hc);
        wr_reg(12'h169, 8'hff);
        rd_chk(12'h169, 8'h00);
        rd_chk(12'h162, 8'h00);
        rd_chk(12'h163, 8'hff);
        rd_chk(12'h166, 8'h1b);
        // Mid-run reset: pins stay at 0f, so the cleared pin history gives one load pulse on oscillators 0 and 1
        rst_n = 1'h0;
        tick();
        chk({conn, load, byp, neg, ph, ll, rv}, {4'h0, 4'h0, 4'hf, 3'h0, 1'h0}, "mid reset");
        rst_n = 1'h1;
        pulse_chk(4'h3);
        rd_chk(12'h163, 8'h00);
        rd_chk(12'h165, 8'h00);
        print_verdict();
    end
endmodule : dcr_regs_bench
`default_nettype wire
